// ---- src/wake_input_latch_control.sv ----
// Functional notes
// - With the clock alarm latch enable set an alarm is held until cleared, otherwise it passes straight through.
// - With the weekly alarm latch enable set an alarm is held until cleared, otherwise it passes straight through.
// - Each wake input with its latch enable set is held until its clear bit is written, otherwise it passes through.
// - Wake inputs are latched after polarity: asserted low when the polarity bit is 0, high when it is 1.
// - Reset clears both alarm latch enables and loads the input latch enable field from the value 30h.
// - Writing one to the clock alarm clear bit resets the clock alarm latch.
// - While the clock alarm is asserted its latch stays set, beating any clear.
// - Writing one to the weekly alarm clear bit resets the weekly alarm latch.
// - While the weekly alarm is asserted its latch stays set, beating any clear.
// - Writing one to an input clear bit returns that input's latched status to one, the inactive level.
// - An asserted wake input overrides its clear, so the latch stays set.
// - The latch clear register is write-only and its read data carries no meaning.
// - An input whose polarity bit is zero is inverted first, so the latch sees an active-high equivalent.
// - With alarm latching enabled the alarm status bit goes to one on assertion and falls only by its clear write.
//
// Our own choice: the Wishbone interface to the registers.
module wake_input_latch_control
  import wake_latch_pkg::*;
#(
  parameter int NUM_INPUTS = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire bus_addr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire bus_word_t wb_dat_i,
  output bus_word_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_INPUTS-1:0] wake_input_pin_i,
  input wire logic clock_alarm_i,
  input wire logic weekly_alarm_i,
  output logic [NUM_INPUTS-1:0] wake_input_status_o,
  output logic clock_alarm_status_o,
  output logic weekly_alarm_status_o,
  output logic irq_o
);

`include "wake_latch_map.svh"

  localparam int NS = NUM_INPUTS + 2;
  localparam int WK = NUM_INPUTS;
  localparam int CK = NUM_INPUTS + 1;

  if (NUM_INPUTS < 1 || NUM_INPUTS > 4) begin : g_bad_param
    $error("NUM_INPUTS must lie between 1 and 4");
  end

  // ****************************************
  // Layout helpers
  // ****************************************
  // Sources are ordered inputs, then weekly alarm, then clock alarm.
  function automatic logic [NS-1:0] unpack(input bus_word_t w);
    logic [NS-1:0] v;
    v = '0;
    v[NUM_INPUTS-1:0] = w[NUM_INPUTS-1:0];
    v[WK] = w[`WL_BIT_WEEKLY];
    v[CK] = w[`WL_BIT_CLOCK];
    return v;
  endfunction

  function automatic bus_word_t pack(input logic [NS-1:0] v);
    bus_word_t w;
    w = '0;
    w[NUM_INPUTS-1:0] = v[NUM_INPUTS-1:0];
    w[`WL_BIT_WEEKLY] = v[WK];
    w[`WL_BIT_CLOCK] = v[CK];
    return w;
  endfunction

  // ****************************************
  // Wishbone decode
  // ****************************************
  logic ack_q;
  bus_word_t rdata_q;
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire [5:0] word_adr = wb_adr_i[7:2];
  wire hit_status = word_adr == `WL_OFF_STATUS >> 2;
  wire hit_enable = word_adr == `WL_OFF_ENABLE >> 2;
  wire hit_clear = word_adr == `WL_OFF_CLEAR >> 2;
  wire hit_pol = word_adr == `WL_OFF_POLARITY >> 2;
  wire hit_irq_st = word_adr == `WL_OFF_IRQ_STATUS >> 2;
  wire hit_irq_mask = word_adr == `WL_OFF_IRQ_MASK >> 2;
  wire bus_word_t lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [NS-1:0] wr_bits = unpack(lane_mask);
  wire [NS-1:0] wr_vals = unpack(wb_dat_i & lane_mask);

  // Reserved bits are never stored, so writes to them vanish.
  wire [NS-1:0] clr_vec = (wr & hit_clear) ? (wr_bits & wr_vals) : '0;

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [NS-1:0] le_q;
  logic [NUM_INPUTS-1:0] pol_q;
  logic [NS-1:0] mask_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      le_q <= unpack(`WL_ENABLE_RESET);
      pol_q <= NUM_INPUTS'(`WL_POLARITY_RESET);
      mask_q <= unpack(`WL_IRQ_MASK_RESET);
    end else begin
      if (wr && hit_enable) begin
        le_q <= (le_q & ~wr_bits) | (wr_bits & wr_vals);
      end
      if (wr && hit_pol) begin
        pol_q <= (pol_q & ~wr_bits[NUM_INPUTS-1:0]) | (wr_bits[NUM_INPUTS-1:0] & wr_vals[NUM_INPUTS-1:0]);
      end
      if (wr && hit_irq_mask) begin
        mask_q <= (mask_q & ~wr_bits) | (wr_bits & wr_vals);
      end
    end
  end

  // ****************************************
  // Input synchronisers and polarity
  // ****************************************
  // Pins and alarms come from other domains, so two flops guard each one.
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  wire [NS-1:0] raw = {clock_alarm_i, weekly_alarm_i, wake_input_pin_i};
  // Flops reset to the idle level of each source under reset polarity, so no false event follows reset.
  localparam logic [NS-1:0] SYNC_IDLE = {2'b00, {NUM_INPUTS{1'b1}}};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  // Active-high assertion per source; pin equal to its polarity bit means asserted.
  wire [NS-1:0] act = {sync2_q[CK], sync2_q[WK], ~(sync2_q[NUM_INPUTS-1:0] ^ pol_q)};

  // ****************************************
  // Latches, one per source
  // ****************************************
  logic [NS-1:0] latch_q;
  logic [NS-1:0] eff;
  logic [NS-1:0] eff_q;
  logic [NS-1:0] act_q;

  for (genvar g = 0; g < NS; g++) begin : g_latch
    // The live source wins over a clear in the same cycle.
    wire set_d = act[g] | (le_q[g] & latch_q[g] & ~clr_vec[g]);
    // A disabled latch follows the source, so no stale event survives enabling.
    assign eff[g] = le_q[g] ? latch_q[g] : act[g];

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        latch_q[g] <= 1'b0;
      end else begin
        latch_q[g] <= set_d;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eff_q <= '0;
      act_q <= '0;
    end else begin
      eff_q <= eff;
      act_q <= act;
    end
  end

  // Input status is active low, alarm status active high.
  assign wake_input_status_o = ~eff_q[NUM_INPUTS-1:0];
  assign weekly_alarm_status_o = eff_q[WK];
  assign clock_alarm_status_o = eff_q[CK];

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [NS-1:0] irq_st_q;
  wire [NS-1:0] rise = act & ~act_q;
  wire irq_read = rd & hit_irq_st;

  // A new event in the reading cycle survives the clear.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= rise | (irq_read ? '0 : irq_st_q);
    end
  end

  assign irq_o = |(irq_st_q & mask_q);

  // ****************************************
  // Read data and acknowledge
  // ****************************************
  wire bus_word_t status_word = pack({eff_q[CK], eff_q[WK], ~eff_q[NUM_INPUTS-1:0]});
  // The clear register reads as zero; software gets nothing useful there.
  wire bus_word_t rd_mux = hit_status ? status_word :
                           hit_enable ? pack(le_q) :
                           hit_pol ? bus_word_t'(pol_q) :
                           hit_irq_st ? pack(irq_st_q) :
                           hit_irq_mask ? pack(mask_q) : '0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req;
      rdata_q <= rd ? rd_mux : '0;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_clock_hold: assert property (
    le_q[CK] && latch_q[CK] && !clr_vec[CK] |=> latch_q[CK]
  ) else $error("clock alarm latch dropped without a clear");

  chk_clock_pass: assert property (
    !le_q[CK] ##1 !le_q[CK] |=> clock_alarm_status_o == $past(act[CK])
  ) else $error("unlatched clock alarm did not pass through");

  chk_weekly_hold: assert property (
    le_q[WK] && latch_q[WK] && !clr_vec[WK] |=> latch_q[WK]
  ) else $error("weekly alarm latch dropped without a clear");

  chk_input_hold: assert property (
    ((le_q & latch_q & ~clr_vec) != '0) |=> ((latch_q & $past(le_q & latch_q & ~clr_vec)) ==
                                              $past(le_q & latch_q & ~clr_vec))
  ) else $error("input latch dropped without a clear");

  chk_polarity_map: assert property (
    $stable(pol_q) && sync2_q[0] == pol_q[0] |-> act[0]
  ) else $error("polarity did not define the asserted level");

  chk_clock_clear: assert property (
    le_q[CK] && clr_vec[CK] && !act[CK] |=> !latch_q[CK] ##1 !clock_alarm_status_o
  ) else $error("clock alarm clear did not reset the latch");

  chk_clock_wins: assert property (
    act[CK] |=> latch_q[CK] ##1 (clock_alarm_status_o || !$past(le_q[CK]))
  ) else $error("clock alarm lost to a clear");

  chk_weekly_clear: assert property (
    le_q[WK] && clr_vec[WK] && !act[WK] |=> !latch_q[WK]
  ) else $error("weekly alarm clear did not reset the latch");

  chk_weekly_wins: assert property (
    act[WK] |=> latch_q[WK] ##1 (weekly_alarm_status_o || !$past(le_q[WK]))
  ) else $error("weekly alarm lost to a clear");

  chk_input_clear: assert property (
    (clr_vec[NUM_INPUTS-1:0] & ~act[NUM_INPUTS-1:0]) != '0 |=>
      (latch_q[NUM_INPUTS-1:0] & $past(clr_vec[NUM_INPUTS-1:0] & ~act[NUM_INPUTS-1:0])) == '0
  ) else $error("input clear did not release the latch");

  chk_input_wins: assert property (
    act != '0 |=> (latch_q & $past(act)) == $past(act)
  ) else $error("asserted input lost to a clear");

  chk_clear_zero: assert property (
    wr && hit_clear && le_q[CK] && latch_q[CK] && !(wb_sel_i[2] && wb_dat_i[`WL_BIT_CLOCK]) |=> latch_q[CK]
  ) else $error("zero written to a clear bit changed the latch");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("acknowledge held longer than one cycle");

  chk_ack_follows: assert property (
    req |=> wb_ack_o
  ) else $error("request not acknowledged in the next cycle");

  chk_read_idle: assert property (
    !wb_ack_o |-> wb_dat_o == '0
  ) else $error("read data not zero outside an acknowledge");

  chk_clear_read: assert property (
    rd && hit_clear |=> wb_dat_o == '0
  ) else $error("clear register read returned data");

  chk_clock_status: assert property (
    le_q[CK] && latch_q[CK] |=> clock_alarm_status_o
  ) else $error("latched clock alarm not shown in status");

  chk_weekly_status: assert property (
    le_q[WK] && latch_q[WK] |=> weekly_alarm_status_o
  ) else $error("latched weekly alarm not shown in status");

  chk_weekly_pass: assert property (
    !le_q[WK] |=> weekly_alarm_status_o == $past(act[WK])
  ) else $error("unlatched weekly alarm did not pass through");

  chk_input_pass: assert property (
    !le_q[0] |=> wake_input_status_o[0] == !$past(act[0])
  ) else $error("unlatched input did not pass through");

  chk_input_latched: assert property (
    le_q[0] && latch_q[0] |=> !wake_input_status_o[0]
  ) else $error("latched input not shown in status");

  chk_enable_write: assert property (
    wr && hit_enable && wb_sel_i == 4'hF |=> le_q == $past(wr_vals)
  ) else $error("latch enable write not stored");

  chk_irq_set: assert property (
    (rise != '0) |=> (irq_st_q & $past(rise)) == $past(rise)
  ) else $error("source event did not set interrupt status");

  chk_irq_clear: assert property (
    irq_read && rise == '0 |=> irq_st_q == '0
  ) else $error("interrupt status read did not clear");

  cov_clock_cycle: cover property (
    le_q[CK] && act[CK] ##1 !act[CK] [*2] ##1 clr_vec[CK] ##1 !latch_q[CK]
  );

  cov_input_blocked: cover property (
    clr_vec[0] && act[0] ##1 latch_q[0]
  );

  cov_irq_read: cover property (
    irq_o ##1 irq_read ##1 !irq_o
  );

  cov_weekly_pass: cover property (
    !le_q[WK] && act[WK] ##1 !act[WK]
  );

  cov_enable_write: cover property (
    wr && hit_enable
  );

endmodule

// ---- src/wake_latch_map.svh ----
`ifndef WAKE_LATCH_MAP_SVH
`define WAKE_LATCH_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define WL_OFF_STATUS 8'h00
`define WL_OFF_ENABLE 8'h04
`define WL_OFF_CLEAR 8'h08
`define WL_OFF_POLARITY 8'h14
`define WL_OFF_IRQ_STATUS 8'h40
`define WL_OFF_IRQ_MASK 8'h44

// ****************************************
// Field positions
// ****************************************
`define WL_BIT_WEEKLY 16
`define WL_BIT_CLOCK 17

// ****************************************
// Reset values
// ****************************************
`define WL_ENABLE_RESET 32'h0000_0030
`define WL_POLARITY_RESET 32'h0000_0000
`define WL_IRQ_MASK_RESET 32'h0000_0000

`endif

// ---- src/wake_latch_pkg.sv ----
package wake_latch_pkg;

  typedef logic [31:0] bus_word_t;
  typedef logic [7:0] bus_addr_t;

endpackage

// ---- verif/test_wake_input_latch_control.sv ----
module test_wake_input_latch_control
  import wake_latch_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, nrst_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  bus_addr_t wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  bus_word_t wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic wb_ack_o, clock_alarm_i, weekly_alarm_i, clock_alarm_status_o, weekly_alarm_status_o, irq_o;
  logic [3:0] pins, status, src = 4'h0, pol = 4'h0;
  logic ca = 1'b0, wa = 1'b0;
  int mismatches = 0, cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  wake_source_model partner (.assert_i(src), .pol_i(pol), .clock_alarm_i(ca), .weekly_alarm_i(wa),
    .wake_input_pin_o(pins), .clock_alarm_o(clock_alarm_i), .weekly_alarm_o(weekly_alarm_i));
  wake_input_latch_control #(.NUM_INPUTS(4)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_input_pin_i(pins), .clock_alarm_i(clock_alarm_i),
    .weekly_alarm_i(weekly_alarm_i), .wake_input_status_o(status), .clock_alarm_status_o(clock_alarm_status_o),
    .weekly_alarm_status_o(weekly_alarm_status_o), .irq_o(irq_o));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The request stands until the rising edge that samples ack high; data is taken at that edge.
  task automatic wb_access(input logic we, input bus_addr_t a, input bus_word_t d, output bus_word_t q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      check("ack wait", 32'h0, 32'h1);
      tally_and_finish();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input bus_addr_t a, input bus_word_t d);
    bus_word_t q;
    wb_access(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input bus_addr_t a, input bus_word_t exp);
    wb_access(1'b0, a, 32'h0000_0000, rd);
    check(what, rd, exp);
  endtask
  task automatic drive(input logic [3:0] s, input logic c, input logic w);
    @(posedge clk_i);
    src <= s;
    ca <= c;
    wa <= w;
    repeat (6) @(posedge clk_i);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk("enable reset", 8'h04, 32'h0000_0000);
    rd_chk("status reset", 8'h00, 32'h0000_000F);
    rd_chk("clear read", 8'h08, 32'h0000_0000);
    rd_chk("unmapped", 8'h80, 32'h0000_0000);
    $display("Test reset done");
    wr(8'h14, 32'h0000_0005);
    pol <= 4'h5;
    wr(8'h04, 32'hFFFF_FFFF);
    rd_chk("enable mask", 8'h04, 32'h0003_000F);
    // The pins follow the new polarity a few cycles after the register, so inputs 0 and 2 blip once.
    rd_chk("irq drain", 8'h40, 32'h0000_0005);
    wb_access(1'b0, 8'h40, 32'h0, rd);
    drive(4'hF, 1'b1, 1'b1);
    drive(4'h0, 1'b0, 1'b0);
    rd_chk("latched", 8'h00, 32'h0003_0000);
    check("latched pins", {28'h0, status}, 32'h0);
    check("latched alarms", {30'h0, clock_alarm_status_o, weekly_alarm_status_o}, 32'h3);
    wr(8'h08, 32'h0000_0000);
    rd_chk("zero clear", 8'h00, 32'h0003_0000);
    drive(4'hF, 1'b1, 1'b1);
    wr(8'h08, 32'h0003_000F);
    rd_chk("clear blocked", 8'h00, 32'h0003_0000);
    drive(4'h0, 1'b0, 1'b0);
    rd_chk("before clear", 8'h00, 32'h0003_0000);
    wr(8'h08, 32'h0003_000F);
    rd_chk("cleared", 8'h00, 32'h0000_000F);
    check("cleared pins", {28'h0, status}, 32'hF);
    check("cleared alarms", {30'h0, clock_alarm_status_o, weekly_alarm_status_o}, 32'h0);
    $display("Test latch done");
    wr(8'h04, 32'h0000_0000);
    drive(4'hA, 1'b1, 1'b0);
    rd_chk("pass asserted", 8'h00, 32'h0002_0005);
    check("pass pins", {28'h0, status}, 32'h5);
    check("pass alarms", {30'h0, clock_alarm_status_o, weekly_alarm_status_o}, 32'h2);
    drive(4'h0, 1'b0, 1'b0);
    rd_chk("pass released", 8'h00, 32'h0000_000F);
    $display("Test passthrough done");
    wb_access(1'b0, 8'h40, 32'h0, rd);
    wr(8'h44, 32'h0002_0000);
    drive(4'h0, 1'b0, 1'b1);
    @(negedge clk_i);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    drive(4'h0, 1'b1, 1'b0);
    @(negedge clk_i);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    rd_chk("irq status", 8'h40, 32'h0003_0000);
    @(negedge clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    $display("Test interrupt done");
    tally_and_finish();
  end
endmodule

// ---- verif/wake_source_model.sv ----
// ****************************************
// Far side: wake pins and alarm sources
// ****************************************
module wake_source_model (
  input wire logic [3:0] assert_i,
  input wire logic [3:0] pol_i,
  input wire logic clock_alarm_i,
  input wire logic weekly_alarm_i,
  output logic [3:0] wake_input_pin_o,
  output logic clock_alarm_o,
  output logic weekly_alarm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // An asserted pin sits at its polarity level, so both pin senses get exercised.
  assign wake_input_pin_o = pol_i ~^ assert_i;
  assign clock_alarm_o = clock_alarm_i;
  assign weekly_alarm_o = weekly_alarm_i;
endmodule
